//--- pkg/sasf_pkg.sv
/*
  Shared constants and types for the speech activity spectral front end.
  Assumes one 125 MHz clock domain and that every user imports it whole.
*/
package sasf_pkg;
  // Data widths; energy and distortion sums keep full precision, predictor products are rescaled
  localparam int ACF_W = 32;
  localparam int NCOEF = 9;
  localparam int HIST_FRAMES = 4;
  localparam int SUM_W = 36;
  localparam int COEF_W = 20;
  localparam int COEF_FRAC = 12;
  localparam int K_W = 16;
  localparam int K_FRAC = 15;
  localparam int ACC_W = 60;
  localparam int RAV_W = 32;
  localparam int ENERGY_W = 72;
  localparam int NUM_W = 76;
  localparam int DM_W = 48;
  localparam int DIV_W = 76;
  localparam int FIFO_DEPTH = 16;
  // Sequencing counts
  localparam logic [6:0] DIV_STEPS = 7'h4C;
  localparam logic [3:0] LAST_IDX = 4'h8;
  localparam logic [3:0] ORDER = 4'h8;
  // Fixed values
  localparam logic signed [COEF_W-1:0] COEF_NEG_ONE = -20'sh01000;
  localparam logic [K_W-1:0] K_MAX = 16'h7FFF;
  localparam logic signed [RAV_W-1:0] W_INIT0 = 32'sh00000006;
  localparam logic signed [RAV_W-1:0] W_INIT1 = -32'sh00000004;
  localparam logic signed [RAV_W-1:0] W_INIT2 = 32'sh00000001;
  localparam logic signed [DM_W-1:0] DM_INIT = 48'sh000000000000;
  localparam real STEADY_THRESH = 0.05;
  localparam logic signed [DM_W:0] STEADY_THRESH_Q =
    (DM_W+1)'($rtoi(STEADY_THRESH * (2.0 ** COEF_FRAC)));

  typedef enum logic [3:0] {
    S_LOAD = 4'h0,
    S_ENERGY = 4'h1,
    S_AVG = 4'h2,
    S_ACC = 4'h3,
    S_DIV = 4'h4,
    S_STEP = 4'h5,
    S_RAV = 4'h6,
    S_DIST = 4'h7,
    S_DDIV = 4'h8,
    S_DONE = 4'h9
  } sasf_state_type;
endpackage

//--- rtl/sasf_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module sasf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) &&
                (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

//--- rtl/sasf_front.sv
/*
  Per-frame spectral front end of a speech activity detector: filtered
  energy, four-frame autocorrelation sums, 8th order predictor, predictor
  autocorrelation, spectral distortion and steady-spectrum flag.
  Assumes the encoder pushes nine signed autocorrelation words per frame,
  index 0 first, and that threshold and weight-update come from
  adaptation logic on the same clock.
*/
`timescale 1ns/1ns
// Function
// - One binary speech flag per 20 ms frame
// - Energy is weighted autocorrelation sum, doubled off-centre
// - Recent sum spans current and three previous frames
// - Delayed sum is recent sum four frames back
// - Solve 8th order equations; coefficient zero is -1
// - Predictor autocorrelation from coefficient lag products
// - Distortion is weighted product sum over recent zero
// - Steady when distortion change below 0.05
// - Speech when energy exceeds decision threshold
// - Weights take predictor autocorrelation only when allowed
module sasf_front
  import sasf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Autocorrelation words from the encoder
  input wire logic [ACF_W-1:0] acf_data,
  input wire logic acf_valid,
  output logic acf_ready,
  // Controls from the adaptation logic
  input wire logic signed [ENERGY_W-1:0] decision_threshold,
  input wire logic weight_update_en,
  // Per-frame results
  output logic result_valid,
  output logic speech_flag,
  output logic steady_flag,
  output logic signed [ENERGY_W-1:0] filtered_energy,
  output logic signed [DM_W-1:0] spectral_distortion,
  output logic [NCOEF-1:0][RAV_W-1:0] predictor_autocorr
);
  sasf_state_type state_r;
  logic [3:0] idx_r;
  logic [3:0] j_r;
  logic [3:0] m_r;
  logic [6:0] dv_cnt_r;
  logic [ACF_W-1:0] fifo_data;
  logic fifo_valid;
  logic pop;

  logic signed [ACF_W-1:0] acf_cur_r [NCOEF];
  logic signed [ACF_W-1:0] acf_hist_r [HIST_FRAMES-1][NCOEF];
  logic signed [SUM_W-1:0] recent_autocorr_sum_r [NCOEF];
  logic signed [SUM_W-1:0] sum_hist_r [HIST_FRAMES][NCOEF];
  logic signed [SUM_W-1:0] delayed_autocorr_sum_r [NCOEF];
  logic signed [COEF_W-1:0] predictor_coeffs_r [NCOEF];
  logic signed [COEF_W-1:0] coef_all [NCOEF];
  logic signed [RAV_W-1:0] rav_r [NCOEF];
  logic signed [RAV_W-1:0] weight_r [NCOEF];
  logic signed [ACC_W-1:0] acc_r;
  logic signed [ACC_W-1:0] err_r;
  logic signed [ACC_W+COEF_FRAC-1:0] rav_acc_r;
  logic signed [ENERGY_W-1:0] energy_r;
  logic signed [NUM_W-1:0] num_r;
  logic [DIV_W-1:0] dv_dvd_r;
  logic [DIV_W-1:0] dv_rem_r;
  logic [DIV_W-1:0] dv_den_r;
  logic [DIV_W-1:0] dv_quo_r;
  logic dv_neg_r;
  logic dv_zero_r;
  logic [DIV_W-1:0] rem_shift;
  logic signed [K_W-1:0] k_cur;
  logic [K_W-1:0] k_mag;
  logic signed [DM_W-1:0] last_dm_r;
  logic signed [DM_W-1:0] dm_nxt;
  logic signed [DM_W:0] dm_diff;
  logic signed [RAV_W-1:0] rav_nxt;

  // Encoder-facing buffer; the sequencer only drains it while loading,
  // so a stalled frame back-pressures the encoder
  sasf_fifo #(.WIDTH(ACF_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(acf_data),
    .in_valid(acf_valid),
    .in_ready(acf_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(state_r == S_LOAD)
  );
  assign pop = fifo_valid && (state_r == S_LOAD);

  // Sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= S_LOAD;
      idx_r <= 4'h0;
      j_r <= 4'h0;
      m_r <= 4'h0;
      dv_cnt_r <= 7'h00;
    end else begin
      case (state_r)
        S_LOAD: begin
          if (pop) begin
            idx_r <= (idx_r == LAST_IDX) ? 4'h0 : idx_r + 4'h1;
            if (idx_r == LAST_IDX) begin
              state_r <= S_ENERGY;
            end
          end
        end
        S_ENERGY: begin
          idx_r <= (idx_r == LAST_IDX) ? 4'h0 : idx_r + 4'h1;
          if (idx_r == LAST_IDX) begin
            state_r <= S_AVG;
          end
        end
        S_AVG: begin
          m_r <= 4'h1;
          j_r <= 4'h1;
          state_r <= S_ACC;
        end
        S_ACC: begin
          if (j_r >= m_r) begin
            state_r <= S_DIV;
          end else begin
            j_r <= j_r + 4'h1;
          end
        end
        S_DIV, S_DDIV: begin
          dv_cnt_r <= (dv_cnt_r == DIV_STEPS) ? 7'h00 : dv_cnt_r + 7'h01;
          if (dv_cnt_r == DIV_STEPS) begin
            state_r <= (state_r == S_DIV) ? S_STEP : S_DONE;
          end
        end
        S_STEP: begin
          j_r <= (m_r == ORDER) ? 4'h0 : 4'h1;
          if (m_r == ORDER) begin
            idx_r <= 4'h0;
            state_r <= S_RAV;
          end else begin
            m_r <= m_r + 4'h1;
            state_r <= S_ACC;
          end
        end
        S_RAV: begin
          if (j_r == LAST_IDX - idx_r) begin
            j_r <= 4'h0;
            idx_r <= (idx_r == LAST_IDX) ? 4'h0 : idx_r + 4'h1;
            if (idx_r == LAST_IDX) begin
              state_r <= S_DIST;
            end
          end else begin
            j_r <= j_r + 4'h1;
          end
        end
        S_DIST: begin
          idx_r <= (idx_r == LAST_IDX) ? 4'h0 : idx_r + 4'h1;
          if (idx_r == LAST_IDX) begin
            state_r <= S_DDIV;
          end
        end
        default: begin
          idx_r <= 4'h0;
          state_r <= S_LOAD;
        end
      endcase
    end
  end

  // Frame capture and four-frame averaging with history from zero
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NCOEF; i++) begin
        acf_cur_r[i] <= '0;
        recent_autocorr_sum_r[i] <= '0;
        delayed_autocorr_sum_r[i] <= '0;
        for (int h = 0; h < HIST_FRAMES - 1; h++) begin
          acf_hist_r[h][i] <= '0;
        end
        for (int h = 0; h < HIST_FRAMES; h++) begin
          sum_hist_r[h][i] <= '0;
        end
      end
    end else if (pop) begin
      acf_cur_r[idx_r] <= $signed(fifo_data);
    end else if (state_r == S_AVG) begin
      for (int i = 0; i < NCOEF; i++) begin
        recent_autocorr_sum_r[i] <= SUM_W'(acf_cur_r[i])
          + SUM_W'(acf_hist_r[0][i]) + SUM_W'(acf_hist_r[1][i])
          + SUM_W'(acf_hist_r[2][i]);
        sum_hist_r[0][i] <= SUM_W'(acf_cur_r[i]) + SUM_W'(acf_hist_r[0][i])
          + SUM_W'(acf_hist_r[1][i]) + SUM_W'(acf_hist_r[2][i]);
        // Oldest stored sum is the one from four frames ago
        delayed_autocorr_sum_r[i] <=
          sum_hist_r[HIST_FRAMES-1][i];
        acf_hist_r[0][i] <= acf_cur_r[i];
        for (int h = 1; h < HIST_FRAMES - 1; h++) begin
          acf_hist_r[h][i] <= acf_hist_r[h-1][i];
        end
        for (int h = 1; h < HIST_FRAMES; h++) begin
          sum_hist_r[h][i] <= sum_hist_r[h-1][i];
        end
      end
    end
  end

  // Filtered energy with the current noise weights
  always_ff @(posedge clk) begin
    if (rst || state_r == S_LOAD) begin
      energy_r <= '0;
    end else if (state_r == S_ENERGY) begin
      energy_r <= energy_r + ((idx_r == 4'h0 ? 1 : 2) *
        ENERGY_W'(weight_r[idx_r]) * ENERGY_W'(acf_cur_r[idx_r]));
    end
  end

  // Saturated reflection coefficient from the divider
  always_comb begin
    k_mag = dv_zero_r ? '0 :
            (dv_quo_r > DIV_W'(K_MAX)) ? K_MAX : dv_quo_r[K_W-1:0];
    k_cur = dv_neg_r ? -$signed(k_mag) : $signed(k_mag);
  end

  // Order-recursive solve on the delayed sum; order 8, unit leading term
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r <= '0;
      err_r <= '0;
      for (int i = 0; i < NCOEF; i++) begin
        predictor_coeffs_r[i] <= '0;
      end
    end else if (state_r == S_AVG) begin
      // Predictor must not see the current, possibly voiced, frame
      err_r <=
        ACC_W'(sum_hist_r[HIST_FRAMES-1][0]) <<< COEF_FRAC;
      acc_r <= ACC_W'(sum_hist_r[HIST_FRAMES-1][1]) <<< COEF_FRAC;
      for (int i = 0; i < NCOEF; i++) begin
        predictor_coeffs_r[i] <= '0;
      end
    end else if (state_r == S_ACC && j_r < m_r) begin
      acc_r <= acc_r - ACC_W'(predictor_coeffs_r[j_r]
        * ACC_W'(delayed_autocorr_sum_r[m_r - j_r]));
    end else if (state_r == S_STEP) begin
      for (int j = 1; j < NCOEF; j++) begin
        if (4'(j) < m_r) begin
          predictor_coeffs_r[j] <= predictor_coeffs_r[j] - COEF_W'(
            (36'(k_cur) * 36'(predictor_coeffs_r[m_r - 4'(j)])) >>> K_FRAC);
        end else if (4'(j) == m_r) begin
          predictor_coeffs_r[j] <= COEF_W'(k_cur >>> (K_FRAC - COEF_FRAC));
        end
      end
      // Prediction error shrinks by k times the residual correlation
      err_r <= err_r - ACC_W'((DIV_W'(k_cur) * DIV_W'(acc_r)) >>> K_FRAC);
      if (m_r != ORDER) begin
        acc_r <= ACC_W'(delayed_autocorr_sum_r[m_r + 4'h1]) <<< COEF_FRAC;
      end
    end
  end

  // Shift-subtract divider shared by the recursion and the distortion
  assign rem_shift = {dv_rem_r[DIV_W-2:0], dv_dvd_r[DIV_W-1]};
  always_ff @(posedge clk) begin
    if (rst) begin
      dv_dvd_r <= '0;
      dv_rem_r <= '0;
      dv_den_r <= '0;
      dv_quo_r <= '0;
      dv_neg_r <= 1'b0;
      dv_zero_r <= 1'b0;
    end else if (dv_cnt_r == 7'h00 && state_r == S_DIV) begin
      dv_dvd_r <= DIV_W'(acc_r < 0 ? -acc_r : acc_r) << K_FRAC;
      dv_den_r <= DIV_W'(err_r);
      dv_neg_r <= acc_r < 0;
      // A non-positive error means a singular system; stop adding terms
      dv_zero_r <= err_r <= 0;
      dv_rem_r <= '0;
      dv_quo_r <= '0;
    end else if (dv_cnt_r == 7'h00 && state_r == S_DDIV) begin
      dv_dvd_r <= DIV_W'(num_r < 0 ? -num_r : num_r);
      dv_den_r <= DIV_W'(recent_autocorr_sum_r[0] < 0 ?
        -recent_autocorr_sum_r[0] : recent_autocorr_sum_r[0]);
      dv_neg_r <= (num_r < 0) != (recent_autocorr_sum_r[0] < 0);
      dv_zero_r <= recent_autocorr_sum_r[0] == 0;
      dv_rem_r <= '0;
      dv_quo_r <= '0;
    end else if (state_r == S_DIV || state_r == S_DDIV) begin
      dv_dvd_r <= dv_dvd_r << 1;
      dv_rem_r <= (rem_shift >= dv_den_r) ? rem_shift - dv_den_r : rem_shift;
      dv_quo_r <= {dv_quo_r[DIV_W-2:0], rem_shift >= dv_den_r};
    end
  end

  // Coefficient vector with its fixed leading term
  always_comb begin
    coef_all[0] = COEF_NEG_ONE;
    for (int i = 1; i < NCOEF; i++) begin
      coef_all[i] = predictor_coeffs_r[i];
    end
  end
  assign rav_nxt = RAV_W'((rav_acc_r + (ACC_W+COEF_FRAC)'(coef_all[j_r]
    * (ACC_W+COEF_FRAC)'(coef_all[j_r + idx_r]))) >>> COEF_FRAC);

  // Predictor autocorrelation, then distortion numerator
  always_ff @(posedge clk) begin
    if (rst) begin
      rav_acc_r <= '0;
      num_r <= '0;
      for (int i = 0; i < NCOEF; i++) begin
        rav_r[i] <= '0;
      end
    end else if (state_r == S_RAV) begin
      num_r <= '0;
      if (j_r == LAST_IDX - idx_r) begin
        rav_r[idx_r] <= rav_nxt;
        rav_acc_r <= '0;
      end else begin
        rav_acc_r <= rav_acc_r + (ACC_W+COEF_FRAC)'(coef_all[j_r]
          * (ACC_W+COEF_FRAC)'(coef_all[j_r + idx_r]));
      end
    end else if (state_r == S_DIST) begin
      num_r <= num_r + ((idx_r == 4'h0 ? 1 : 2) *
        NUM_W'(rav_r[idx_r]) * NUM_W'(recent_autocorr_sum_r[idx_r]));
    end
  end

  // Distortion quotient and its change since the last frame
  always_comb begin
    dm_nxt = dv_zero_r ? DM_INIT : (dv_neg_r ?
      -$signed(dv_quo_r[DM_W-1:0]) : $signed(dv_quo_r[DM_W-1:0]));
    dm_diff = (DM_W+1)'(dm_nxt) - (DM_W+1)'(last_dm_r);
  end

  // Registered per-frame results and the last frame's distortion
  always_ff @(posedge clk) begin
    if (rst) begin
      result_valid <= 1'b0;
      speech_flag <= 1'b0;
      steady_flag <= 1'b0;
      filtered_energy <= '0;
      spectral_distortion <= DM_INIT;
      last_dm_r <= DM_INIT;
      predictor_autocorr <= '0;
    end else begin
      result_valid <= state_r == S_DONE;
      if (state_r == S_DONE) begin
        filtered_energy <= energy_r;
        // Energy comparator decides speech for this frame
        speech_flag <= energy_r > decision_threshold;
        spectral_distortion <= dm_nxt;
        steady_flag <= (dm_diff < 0 ? -dm_diff : dm_diff)
          < STEADY_THRESH_Q;
        last_dm_r <= dm_nxt;
        for (int i = 0; i < NCOEF; i++) begin
          predictor_autocorr[i] <= rav_r[i];
        end
      end
    end
  end

  // Weights only follow the predictor when adaptation permits
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NCOEF; i++) begin
        weight_r[i] <= '0;
      end
      weight_r[0] <= W_INIT0;
      weight_r[1] <= W_INIT1;
      weight_r[2] <= W_INIT2;
    end else if (state_r == S_DONE && weight_update_en) begin
      for (int i = 0; i < NCOEF; i++) begin
        weight_r[i] <= rav_r[i];
      end
    end
  end

  // Checking helpers
  logic [3:0] pops_r;
  logic [2:0] frames_r;
  logic signed [DM_W-1:0] prev_dm_chk_r;
  logic signed [DM_W:0] chk_diff;
  always_ff @(posedge clk) begin
    if (rst) begin
      pops_r <= 4'h0;
      frames_r <= 3'h0;
      prev_dm_chk_r <= DM_INIT;
    end else begin
      pops_r <= result_valid ? 4'(pop) : pops_r + 4'(pop);
      if (state_r == S_AVG && frames_r != 3'h7) begin
        frames_r <= frames_r + 3'h1;
      end
      if (result_valid) begin
        prev_dm_chk_r <= spectral_distortion;
      end
    end
  end
  assign chk_diff = (DM_W+1)'(spectral_distortion)
    - (DM_W+1)'(prev_dm_chk_r);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_SPEECH_CMP: assert property ((state_r == S_DONE) |=>
    speech_flag == (filtered_energy > $past(decision_threshold)))
    else $error("speech flag disagrees with energy compare");
  AST_STEADY: assert property (result_valid |->
    steady_flag == ((chk_diff < 0 ? -chk_diff : chk_diff) < STEADY_THRESH_Q))
    else $error("steady flag disagrees with distortion change");
  AST_VALID_PULSE: assert property (
    result_valid |=> !result_valid)
    else $error("result valid longer than one cycle");
  AST_NINE_WORDS: assert property (
    result_valid |-> pops_r == 4'h9)
    else $error("frame did not consume nine words");
  AST_RAV_ZERO: assert property (result_valid |->
    $signed(predictor_autocorr[0]) >= RAV_W'(32'sh00001000))
    else $error("predictor autocorrelation at lag zero below one");
  AST_ENERGY_LEN: assert property (
    $rose(state_r == S_ENERGY) |-> (state_r == S_ENERGY)[*8]
    ##1 (state_r == S_ENERGY) ##1 (state_r == S_AVG))
    else $error("energy sum did not take nine terms");
  AST_DELAY_ZERO: assert property (
    (state_r == S_AVG && frames_r < 3'h4) |=> delayed_autocorr_sum_r[0] == 0)
    else $error("delayed sum not zero in first four frames");
  AST_WEIGHT_HOLD: assert property (
    (state_r != S_DONE || !weight_update_en)
    |=> $stable(weight_r[0]) && $stable(weight_r[1]))
    else $error("weights changed without permission");
  AST_ORDER_END: assert property (
    (state_r == S_STEP && m_r == ORDER) |=> state_r == S_RAV)
    else $error("recursion did not stop at order eight");
  AST_FRAME_LAT: assert property ((pop && idx_r == LAST_IDX) |->
    ##[1:1000] result_valid)
    else $error("frame results late");

  COV_SPEECH: cover property (result_valid && speech_flag);
  COV_STEADY: cover property (result_valid && steady_flag);
  COV_ADAPT: cover property (state_r == S_DONE && weight_update_en);
endmodule

//--- tb/sasf_enc_model.sv
/*
  Encoder-side model: offers autocorrelation words on valid/ready.
  Assumes the bench calls its tasks and shares the clock with the front.
*/
`timescale 1ns/1ns
module sasf_enc_model
  import sasf_pkg::*;
(
  // Clock
  input wire logic clk,
  // Stream to the front end
  output logic [ACF_W-1:0] acf_data,
  output logic acf_valid,
  input wire logic acf_ready
);
  initial begin
    acf_data = 32'h0;
    acf_valid = 1'b0;
  end
  // Released data is inverted so a stale word never looks current
  task automatic idle();
    @(negedge clk);
    acf_valid = 1'b0;
    acf_data = ~acf_data;
  endtask
  // Only autocorrelation words are modelled; lags and frame unused
  task automatic send_word(input logic [ACF_W-1:0] d, input int gap);
    if (gap > 0) begin
      idle();
      repeat (gap - 1) @(negedge clk);
    end
    @(negedge clk);
    acf_data = d;
    acf_valid = 1'b1;
    while (acf_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
endmodule

//--- tb/tb_sasf_front.sv
/*
  Self-checking bench for the spectral front end.
  Assumes the encoder model drives the stream and weights start 6,-4,1.
*/
`timescale 1ns/1ns
module tb_sasf_front
  import sasf_pkg::*;
;
  logic clk, rst, weight_update_en, result_valid, speech_flag, steady_flag;
  logic acf_valid, acf_ready;
  logic [ACF_W-1:0] acf_data;
  logic signed [ENERGY_W-1:0] decision_threshold, filtered_energy;
  logic signed [DM_W-1:0] spectral_distortion;
  logic [NCOEF-1:0][RAV_W-1:0] predictor_autocorr;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int frames_out = 0;
  logic [31:0] seed = 32'h00006826;
  logic signed [ENERGY_W-1:0] w [NCOEF];
  logic signed [ENERGY_W-1:0] exp_e [$];
  logic exp_s [$];

  sasf_front sasf_front_i (.clk(clk), .rst(rst), .acf_data(acf_data),
    .acf_valid(acf_valid), .acf_ready(acf_ready),
    .decision_threshold(decision_threshold),
    .weight_update_en(weight_update_en), .result_valid(result_valid),
    .speech_flag(speech_flag), .steady_flag(steady_flag),
    .filtered_energy(filtered_energy),
    .spectral_distortion(spectral_distortion),
    .predictor_autocorr(predictor_autocorr));
  sasf_enc_model sasf_enc_model_i (.clk(clk), .acf_data(acf_data),
    .acf_valid(acf_valid), .acf_ready(acf_ready));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic signed [ENERGY_W-1:0] energy(
    input logic signed [ACF_W-1:0] a [NCOEF]);
    logic signed [ENERGY_W-1:0] s;
    s = w[0] * a[0];
    for (int i = 1; i < NCOEF; i++) s += 2 * w[i] * a[i];
    return s;
  endfunction

  task automatic check_num(input logic [ENERGY_W-1:0] got, exp,
    input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s %0h not %0h", $time, what, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s flag %b", $time, what, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Modes: 0 threshold equals energy, 1 one below, 2 random, 3 keep
  task automatic frame(input int mode, input bit stall);
    logic signed [ACF_W-1:0] a [NCOEF];
    logic signed [ENERGY_W-1:0] e;
    logic [31:0] r;
    for (int i = 0; i < NCOEF; i++) begin
      r = xs();
      // Lag 0 dominates as it would for 16-bit input samples
      a[i] = (i == 0) ? {8'h00, 1'b1, r[22:0]}
        : {{8{r[23]}}, r[23:0]};
    end
    e = energy(a);
    r = xs();
    if (mode < 3) begin
      @(negedge clk);
      decision_threshold = (mode == 0) ? e : (mode == 1) ? e - 72'sh1 :
        e + $signed({{40{r[31]}}, r});
    end
    exp_e.push_back(e);
    exp_s.push_back(e > decision_threshold);
    for (int i = 0; i < NCOEF; i++)
      sasf_enc_model_i.send_word(a[i], stall ? int'(xs() % 4) : 0);
  endtask

  task automatic settle();
    sasf_enc_model_i.idle();
    while (exp_e.size() != 0) @(negedge clk);
  endtask

  // Results are read mid-cycle, after the launching edge has settled
  always @(negedge clk) begin
    if (!rst && result_valid === 1'b1) begin
      if (exp_e.size() == 0) begin
        num_errors++;
        $display("wrong value at %0t: result without a frame", $time);
      end else begin
        check_num(filtered_energy, exp_e.pop_front(), "energy");
        check_flag(speech_flag, exp_s.pop_front(), "speech");
        // Delayed sum is still zero, so the predictor is trivial
        if (frames_out < 4) begin
          check_num(ENERGY_W'(predictor_autocorr[0]), 72'h1000,
            "rav0");
          for (int i = 1; i < NCOEF; i++)
            check_num(ENERGY_W'(predictor_autocorr[i]), 72'h0,
              "rav");
          check_num(ENERGY_W'(spectral_distortion), 72'h1000,
            "dm");
          check_flag(steady_flag, frames_out != 0, "steady");
        end
        frames_out++;
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("wrong value at %0t: run timed out", $time);
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    weight_update_en = 1'b0;
    decision_threshold = 72'sh0;
    foreach (w[i]) w[i] = 72'sh0;
    w[0] = W_INIT0;
    w[1] = W_INIT1;
    w[2] = W_INIT2;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int f = 0; f < 4; f++) begin
      @(negedge clk);
      weight_update_en = (f == 3);
      frame(f % 3, f[0]);
      settle();
      $display("frame %0d done", f);
    end
    // Weights now hold the trivial predictor autocorrelation
    foreach (w[i]) w[i] = 72'sh0;
    w[0] = 72'sh1000;
    @(negedge clk);
    weight_update_en = 1'b0;
    // Back-to-back burst fills the FIFO while the block computes, stalling the encoder
    frame(2, 1'b0);
    for (int f = 0; f < 4; f++) frame(3, f == 3);
    settle();
    $display("burst done");
    check_num(ENERGY_W'(frames_out), 72'h9, "result count");
    check_num(ENERGY_W'(frames_out), 72'h9,
      "one flag per frame");
    wrap_up();
  end
endmodule
